// ===== core/pup_pkg.sv
// Constants and types shared by the protection unit register block.
// Notes on behaviour
// - Flash violation sets the flash event register to 1; resets to 0.
// - Violation on any peripheral sets the peripheral event register to 1.
// - RAM violation sets the RAM event register to 1.
// - Each event has a publish register with a channel index field.
// - Publish register enable bit gates publishing; register resets to 0.
// - Interrupt enable register holds one read/write bit per event.
// - Writing 1 to the set alias enables; reading returns enable state.
// - Writing 1 to the clear alias disables; reading returns enable state.
// - Capability register is read-only and reads 1, support present.
// - External master attribute source field is read-only: 0, 1 or 2.
// - Security attribute bit acts only when the source reads software chosen.
// - Lock bit set freezes the external master permission register until reset.
// - Channel secure map has 16 bits, 1 secure, resets to all ones.
// - Non-secure event aimed at a secure channel is ignored.
// - Channel map lock bit set blocks map changes until reset.
package pup_pkg;
	localparam logic [11:0] OFS_RAM_EVT      = 12'h100;
	localparam logic [11:0] OFS_FLASH_EVT    = 12'h104;
	localparam logic [11:0] OFS_PERIPH_EVT   = 12'h108;
	localparam logic [11:0] OFS_RAM_PUB      = 12'h180;
	localparam logic [11:0] OFS_FLASH_PUB    = 12'h184;
	localparam logic [11:0] OFS_PERIPH_PUB   = 12'h188;
	localparam logic [11:0] OFS_IRQ_EN       = 12'h300;
	localparam logic [11:0] OFS_IRQ_SET      = 12'h304;
	localparam logic [11:0] OFS_IRQ_CLR      = 12'h308;
	localparam logic [11:0] OFS_FEATURES     = 12'h400;
	localparam logic [11:0] OFS_EXT_PERM     = 12'h440;
	localparam logic [11:0] OFS_CHAN_MAP     = 12'h480;
	localparam logic [11:0] OFS_CHAN_LOCK    = 12'h484;
	localparam int          PUB_EN_BIT       = 31;
	localparam int          CHANNEL_INDEX_W          = 4;
	localparam int          NUM_EVT          = 3;
	localparam int          EVT_RAM          = 0;
	localparam int          EVT_FLASH        = 1;
	localparam int          EVT_PERIPH       = 2;
	localparam int          NUM_CHAN         = 16;
	localparam int          EXT_SECURITY_ATTRIBUTE_BIT  = 4;
	localparam int          EXT_LOCK_BIT     = 8;
	localparam logic [1:0]  SRC_NONSECURE    = 2'h0;
	localparam logic [1:0]  SRC_SECURE       = 2'h1;
	localparam logic [1:0]  SRC_SOFTWARE     = 2'h2;
	localparam logic [31:0] FEATURES_RESET   = 32'h0000_0001;
	localparam logic [15:0] CHAN_MAP_RESET   = 16'hffff;
	localparam logic [31:0] PUB_RESET        = 32'h0000_0000;
	typedef struct packed {
		logic [NUM_EVT-1:0]          evt;
		logic [NUM_EVT-1:0]          irq_en;
		logic [NUM_EVT-1:0]          pub_en;
		logic [NUM_EVT*CHANNEL_INDEX_W-1:0]  pub_idx;
		logic                        ext_security_attribute;
		logic                        ext_lock;
		logic [NUM_CHAN-1:0]         chan_map;
		logic                        chan_lock;
		logic                        ack;
		logic [31:0]                 rdata;
		logic                        irq;
	} pup_state_t;
endpackage : pup_pkg

// ===== core/pup_sync.sv
// Two flip-flop synchroniser for asynchronous pulse inputs.
`timescale 1ns/1ps
`default_nettype none
module pup_sync #(
	parameter int W = 3
) (
	// Clock and reset.
	input  wire logic         clock_in,
	input  wire logic         rstn_in,
	// Data.
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // pup_sync
`default_nettype wire

// ===== core/pup_publish.sv
// Routes one violation event pulse to its selected event routing channel.
`timescale 1ns/1ps
`default_nettype none
module pup_publish (
	// Clock and reset.
	input  wire logic                            clock_in,
	input  wire logic                            rstn_in,
	// Configuration.
	input  wire logic                            enable_in,
	input  wire logic [pup_pkg::CHANNEL_INDEX_W-1:0]     channel_index_in,
	input  wire logic                            source_secure_in,
	input  wire logic [pup_pkg::NUM_CHAN-1:0]    chan_map_in,
	// Event.
	input  wire logic                            event_in,
	output logic      [pup_pkg::NUM_CHAN-1:0]    channel_out
);
	logic allowed;
	always_comb begin
		allowed = source_secure_in || !chan_map_in[channel_index_in];
	end
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			channel_out <= '0;
		end else begin
			channel_out <= '0;
			if (event_in && enable_in && allowed) begin
				channel_out[channel_index_in] <= 1'b1;
			end
		end
	end
endmodule // pup_publish
`default_nettype wire

// ===== core/pup_regs.sv
// Register block of the protection unit with a classic Wishbone slave.
`timescale 1ns/1ps
`default_nettype none
module pup_regs (
	// Clock and reset.
	input  wire logic        clock_in,
	input  wire logic        rstn_in,
	// Wishbone slave.
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [11:0] wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	// Violation detectors, asynchronous pulses or levels.
	input  wire logic        ram_violation_in,
	input  wire logic        flash_violation_in,
	input  wire logic        periph_violation_in,
	// Security of the event source peripheral, 1 secure.
	input  wire logic        source_secure_in,
	// External master strap for its attribute source.
	input  wire logic [1:0]  attribute_source_in,
	// Outputs.
	output logic             irq_out,
	output logic      [15:0] event_routing_channel_out,
	output logic             external_master_secure_out,
	output logic      [15:0] chan_secure_out
);
	pup_pkg::pup_state_t st;
	pup_pkg::pup_state_t next_st;
	logic [2:0]  viol_sync;
	logic [2:0]  viol_prev;
	logic [2:0]  viol_rise;
	logic [1:0]  attr_src;
	logic        ext_secure;
	logic [15:0] chan_pub [3];
	logic [15:0] chan_or;

	pup_sync #(.W(3)) u_sync (
		.clock_in (clock_in),
		.rstn_in  (rstn_in),
		.async_in ({periph_violation_in, flash_violation_in, ram_violation_in}),
		.sync_out (viol_sync)
	);

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// The strap is a pin, so it passes two flip-flops before the decode reads it.
	pup_sync #(.W(2)) u_strap_sync (
		.clock_in (clock_in),
		.rstn_in  (rstn_in),
		.async_in (attribute_source_in),
		.sync_out (attr_src)
	);

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			viol_prev <= '0;
		end else begin
			viol_prev <= viol_sync;
		end
	end
	assign viol_rise = viol_sync & ~viol_prev;

	generate
		for (genvar g = 0; g < pup_pkg::NUM_EVT; g++) begin : g_pub
			pup_publish u_pub (
				.clock_in         (clock_in),
				.rstn_in          (rstn_in),
				.enable_in        (st.pub_en[g]),
				.channel_index_in (st.pub_idx[g*pup_pkg::CHANNEL_INDEX_W +: pup_pkg::CHANNEL_INDEX_W]),
				.source_secure_in (source_secure_in),
				.chan_map_in      (st.chan_map),
				.event_in         (viol_rise[g]),
				.channel_out      (chan_pub[g])
			);
		end
	endgenerate
	assign chan_or = chan_pub[0] | chan_pub[1] | chan_pub[2];

	always_comb begin
		logic        req;
		logic        wr;
		logic [31:0] wv;
		logic [31:0] rv;
		logic [31:0] cur;
		req = wb_cyc_in && wb_stb_in && !st.ack;
		wr  = req && wb_we_in;
		wv  = 32'h0000_0000;
		rv  = 32'h0000_0000;
		cur = 32'h0000_0000;
		next_st       = st;
		next_st.ack   = req;
		// Event registers; hardware set wins over a software write.
		if (wr && wb_adr_in == pup_pkg::OFS_RAM_EVT) begin
			wv = lane_merge({31'h0, st.evt[pup_pkg::EVT_RAM]}, wb_dat_in, wb_sel_in);
			next_st.evt[pup_pkg::EVT_RAM] = wv[0];
		end
		if (wr && wb_adr_in == pup_pkg::OFS_FLASH_EVT) begin
			wv = lane_merge({31'h0, st.evt[pup_pkg::EVT_FLASH]}, wb_dat_in, wb_sel_in);
			next_st.evt[pup_pkg::EVT_FLASH] = wv[0];
		end
		if (wr && wb_adr_in == pup_pkg::OFS_PERIPH_EVT) begin
			wv = lane_merge({31'h0, st.evt[pup_pkg::EVT_PERIPH]}, wb_dat_in, wb_sel_in);
			next_st.evt[pup_pkg::EVT_PERIPH] = wv[0];
		end
		if (viol_rise[pup_pkg::EVT_RAM]) begin
			next_st.evt[pup_pkg::EVT_RAM] = 1'b1;
		end
		if (viol_rise[pup_pkg::EVT_FLASH]) begin
			next_st.evt[pup_pkg::EVT_FLASH] = 1'b1;
		end
		if (viol_rise[pup_pkg::EVT_PERIPH]) begin
			next_st.evt[pup_pkg::EVT_PERIPH] = 1'b1;
		end
		// Publish registers.
		for (int e = 0; e < pup_pkg::NUM_EVT; e++) begin
			cur = {st.pub_en[e], 27'h0, st.pub_idx[e*pup_pkg::CHANNEL_INDEX_W +: pup_pkg::CHANNEL_INDEX_W]};
			if (wr && wb_adr_in == pup_pkg::OFS_RAM_PUB + 12'(4 * e)) begin
				wv = lane_merge(cur, wb_dat_in, wb_sel_in);
				next_st.pub_en[e] = wv[pup_pkg::PUB_EN_BIT];
				next_st.pub_idx[e*pup_pkg::CHANNEL_INDEX_W +: pup_pkg::CHANNEL_INDEX_W] = wv[3:0];
			end
		end
		// Interrupt enable and its aliases.
		if (wr && wb_adr_in == pup_pkg::OFS_IRQ_EN && wb_sel_in[0]) begin
			next_st.irq_en = wb_dat_in[2:0];
		end else if (wr && wb_adr_in == pup_pkg::OFS_IRQ_SET && wb_sel_in[0]) begin
			next_st.irq_en = st.irq_en | wb_dat_in[2:0];
		end else if (wr && wb_adr_in == pup_pkg::OFS_IRQ_CLR && wb_sel_in[0]) begin
			next_st.irq_en = st.irq_en & ~wb_dat_in[2:0];
		end
		// External master permission.
		if (wr && wb_adr_in == pup_pkg::OFS_EXT_PERM && !st.ext_lock) begin
			if (wb_sel_in[0]) begin
				next_st.ext_security_attribute = wb_dat_in[pup_pkg::EXT_SECURITY_ATTRIBUTE_BIT];
			end
			if (wb_sel_in[1]) begin
				next_st.ext_lock = wb_dat_in[pup_pkg::EXT_LOCK_BIT];
			end
		end
		// Channel secure map and its lock.
		if (wr && wb_adr_in == pup_pkg::OFS_CHAN_MAP && !st.chan_lock) begin
			wv = lane_merge({16'h0, st.chan_map}, wb_dat_in, wb_sel_in);
			next_st.chan_map = wv[15:0];
		end
		if (wr && wb_adr_in == pup_pkg::OFS_CHAN_LOCK && wb_sel_in[0] && wb_dat_in[0]) begin
			next_st.chan_lock = 1'b1;
		end
		// Read decode; unmapped addresses read zero and still acknowledge.
		if (wb_adr_in == pup_pkg::OFS_RAM_EVT) begin
			rv = {31'h0, st.evt[pup_pkg::EVT_RAM]};
		end else if (wb_adr_in == pup_pkg::OFS_FLASH_EVT) begin
			rv = {31'h0, st.evt[pup_pkg::EVT_FLASH]};
		end else if (wb_adr_in == pup_pkg::OFS_PERIPH_EVT) begin
			rv = {31'h0, st.evt[pup_pkg::EVT_PERIPH]};
		end else if (wb_adr_in == pup_pkg::OFS_RAM_PUB) begin
			rv = {st.pub_en[0], 27'h0, st.pub_idx[3:0]};
		end else if (wb_adr_in == pup_pkg::OFS_FLASH_PUB) begin
			rv = {st.pub_en[1], 27'h0, st.pub_idx[7:4]};
		end else if (wb_adr_in == pup_pkg::OFS_PERIPH_PUB) begin
			rv = {st.pub_en[2], 27'h0, st.pub_idx[11:8]};
		end else if (wb_adr_in == pup_pkg::OFS_IRQ_EN || wb_adr_in == pup_pkg::OFS_IRQ_SET
			|| wb_adr_in == pup_pkg::OFS_IRQ_CLR) begin
			rv = {29'h0, st.irq_en};
		end else if (wb_adr_in == pup_pkg::OFS_FEATURES) begin
			rv = pup_pkg::FEATURES_RESET;
		end else if (wb_adr_in == pup_pkg::OFS_EXT_PERM) begin
			rv = {23'h0, st.ext_lock, 3'h0, st.ext_security_attribute, 2'h0, attr_src};
		end else if (wb_adr_in == pup_pkg::OFS_CHAN_MAP) begin
			rv = {16'h0, st.chan_map};
		end else if (wb_adr_in == pup_pkg::OFS_CHAN_LOCK) begin
			rv = {31'h0, st.chan_lock};
		end
		next_st.rdata = req ? rv : st.rdata;
		next_st.irq   = |(next_st.evt & next_st.irq_en);
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st          <= '0;
			st.chan_map <= pup_pkg::CHAN_MAP_RESET;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		if (attr_src == pup_pkg::SRC_SOFTWARE) begin
			ext_secure = st.ext_security_attribute;
		end else begin
			ext_secure = (attr_src == pup_pkg::SRC_SECURE);
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			event_routing_channel_out  <= '0;
			external_master_secure_out <= 1'b0;
		end else begin
			event_routing_channel_out  <= chan_or;
			external_master_secure_out <= ext_secure;
		end
	end
	assign wb_dat_out      = st.rdata;
	assign wb_ack_out      = st.ack;
	assign irq_out         = st.irq;
	assign chan_secure_out = st.chan_map;

	// Assertions.
	property irq_follow_p;
		@(posedge clock_in) disable iff (!rstn_in)
		irq_out == |(st.evt & st.irq_en);
	endproperty
	irq_level_a: assert property (irq_follow_p) else $error("irq mismatch");
	evt_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		viol_rise[pup_pkg::EVT_FLASH] |=> st.evt[pup_pkg::EVT_FLASH])
		else $error("flash event not set");
	periph_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		viol_rise[pup_pkg::EVT_PERIPH] |=> st.evt[pup_pkg::EVT_PERIPH])
		else $error("periph event not set");
	ram_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		viol_rise[pup_pkg::EVT_RAM] |=> st.evt[pup_pkg::EVT_RAM])
		else $error("ram event not set");
	sequence set_write_s;
		wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0]
			&& wb_adr_in == pup_pkg::OFS_IRQ_SET;
	endsequence
	enable_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		set_write_s |=> ((st.irq_en & $past(wb_dat_in[2:0])) == $past(wb_dat_in[2:0])
		&& (st.irq_en & $past(st.irq_en)) == $past(st.irq_en)))
		else $error("enable set alias wrong");
	enable_clear_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in[0]
		&& wb_adr_in == pup_pkg::OFS_IRQ_CLR)
		|=> st.irq_en == ($past(st.irq_en) & ~$past(wb_dat_in[2:0])))
		else $error("enable clear alias wrong");
	ext_locked_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		st.ext_lock |=> st.ext_lock && $stable(st.ext_security_attribute))
		else $error("external permission changed while locked");
	map_locked_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		st.chan_lock |=> st.chan_lock && $stable(st.chan_map))
		else $error("channel map changed while locked");
	ack_pulse_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
		else $error("ack not single cycle");
endmodule // pup_regs
`default_nettype wire

// ===== testbench/tb_protection_unit_registers.sv
// Self-checking bench for the protection unit register block.
`timescale 1ns/1ps
`default_nettype none
module tb_protection_unit_registers;
	logic        clock_in;
	logic        rstn_in;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [11:0] adr;
	logic [31:0] dat;
	logic [3:0]  sel;
	logic [31:0] rdat;
	logic [31:0] dout;
	logic [2:0]  vio;
	logic        src_sec;
	logic        cap_clr;
	logic        ack;
	logic        irq;
	logic        ext_sec;
	logic [1:0]  strap;
	logic [15:0] chan;
	logic [15:0] chmap;
	logic [15:0] cap;
	int          miscompares;
	int          comparisons;
	logic [11:0] ra [14];
	logic [31:0] rv [14];

	pup_regs DUT (
		.clock_in(clock_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
		.wb_dat_out(dout), .wb_ack_out(ack), .ram_violation_in(vio[0]),
		.flash_violation_in(vio[1]), .periph_violation_in(vio[2]),
		.source_secure_in(src_sec), .attribute_source_in(strap), .irq_out(irq),
		.event_routing_channel_out(chan), .external_master_secure_out(ext_sec),
		.chan_secure_out(chmap)
	);

	always #20 clock_in = ~clock_in;

	// Collects every channel pulse since the last clear.
	always @(posedge clock_in) begin
		if (cap_clr) begin
			cap <= 16'h0000;
		end else begin
			cap <= cap | chan;
		end
	end

	task automatic final_report();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic Wishbone cycle; read data lands in rdat.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clock_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do begin
			@(posedge clock_in);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			miscompares++;
			final_report();
		end
		rdat = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
		chk(rdat, exp);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask

	// Pulses one violation pin and clears the channel capture.
	task automatic hit(input int i);
		@(posedge clock_in);
		vio[i] <= 1'b1;
		cap_clr <= 1'b1;
		@(posedge clock_in);
		cap_clr <= 1'b0;
		@(posedge clock_in);
		vio[i] <= 1'b0;
		tick(6);
	endtask

	initial begin
		clock_in = 1'b0;
		rstn_in = 1'b0;
		{cyc, stb, we, cap_clr, src_sec} = '0;
		adr = 12'h000;
		sel = 4'h0;
		dat = 32'h0000_0000;
		vio = 3'h0;
		strap = 2'h2;
		miscompares = 0;
		comparisons = 0;
		ra = '{12'h100, 12'h104, 12'h108, 12'h180, 12'h184, 12'h188, 12'h300,
			12'h304, 12'h308, 12'h400, 12'h440, 12'h480, 12'h484, 12'h7fc};
		rv = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 32'h0000_0001, 32'h0000_0002,
			32'h0000_ffff, 0, 0};
		tick(16);
		rstn_in <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			rd(ra[i], rv[i]);
		end
		chk({31'h0, irq}, 32'h0000_0000);
		chk({16'h0, chmap}, 32'h0000_ffff);
		wr(12'h400, 32'h0000_0000);
		rd(12'h400, 32'h0000_0001);
		wr(12'h7fc, 32'hffff_ffff);
		rd(12'h7fc, 32'h0000_0000);
		$display("test reset values done");
		wr(12'h304, 32'h0000_0007);
		rd(12'h300, 32'h0000_0007);
		wr(12'h308, 32'h0000_0002);
		rd(12'h304, 32'h0000_0005);
		wr(12'h304, 32'h0000_0000);
		wr(12'h308, 32'h0000_0000);
		rd(12'h308, 32'h0000_0005);
		wr(12'h300, 32'h0000_0002);
		rd(12'h300, 32'h0000_0002);
		wr(12'h300, 32'h0000_0000);
		$display("test interrupt enables done");
		for (int i = 0; i < 3; i++) begin
			hit(i);
			rd(12'h100 + 12'(4 * i), 32'h0000_0001);
			chk({31'h0, irq}, 32'h0000_0000);
			wr(12'h304, 32'h0000_0001 << i);
			tick(2);
			chk({31'h0, irq}, 32'h0000_0001);
			wr(12'h100 + 12'(4 * i), 32'h0000_0000);
			tick(2);
			chk({31'h0, irq}, 32'h0000_0000);
			wr(12'h308, 32'h0000_0007);
		end
		$display("test events and interrupt done");
		wr(12'h184, 32'h8000_0005);
		hit(1);
		chk({16'h0, cap}, 32'h0000_0000);
		wr(12'h480, 32'h0000_ffdf);
		hit(1);
		chk({16'h0, cap}, 32'h0000_0020);
		src_sec <= 1'b1;
		wr(12'h480, 32'h0000_ffff);
		wr(12'h188, 32'h8000_0003);
		hit(2);
		chk({16'h0, cap}, 32'h0000_0008);
		wr(12'h180, 32'h0000_0007);
		hit(0);
		chk({16'h0, cap}, 32'h0000_0000);
		rd(12'h180, 32'h0000_0007);
		$display("test publishing done");
		wr(12'h440, 32'h0000_0013);
		rd(12'h440, 32'h0000_0012);
		chk({31'h0, ext_sec}, 32'h0000_0001);
		for (int s = 0; s < 3; s++) begin
			@(posedge clock_in);
			strap <= 2'(s);
			tick(4);
			chk({31'h0, ext_sec}, (s == 0) ? 0 : 1);
		end
		bus(1'b1, 12'h440, 32'h0000_0100, 4'h1);
		rd(12'h440, 32'h0000_0002);
		wr(12'h440, 32'h0000_0100);
		wr(12'h440, 32'h0000_0010);
		rd(12'h440, 32'h0000_0102);
		$display("test external master done");
		wr(12'h480, 32'h0000_1234);
		rd(12'h480, 32'h0000_1234);
		wr(12'h484, 32'h0000_0001);
		wr(12'h480, 32'h0000_ffff);
		rd(12'h480, 32'h0000_1234);
		chk({16'h0, chmap}, 32'h0000_1234);
		$display("test channel lock done");
		final_report();
	end
endmodule // tb_protection_unit_registers
`default_nettype wire
